// ==== rtl/cfgee_top.sv ====
/*
 * Configuration memory with serial configuration streaming and a two-wire
 * programming port: page writes, reads, security fuse and chip erase.
 * Assumes the serial clock pin is both the link clock of the streamer and
 * the two-wire clock, oversampled here on the system clock.
 */
`timescale 1ns/10ps
module cfgee_top #(
  parameter logic [cfgee_pkg::TMR_W-1:0] T_WR_CYC = cfgee_pkg::T_WR_CYC,
  parameter logic [cfgee_pkg::TMR_W-1:0] T_EC_CYC = cfgee_pkg::T_EC_CYC
) (
  input  wire logic clk_sys_i,                  // system clock
  input  wire logic rstn_i,                     // async reset, active low
  input  wire logic config_serial_clock_i,      // serial link clock pin
  input  wire logic serial_program_select_i,    // low: programming mode
  input  wire logic chip_select_i,              // chip select pin
  input  wire logic reset_oe_i,                 // counter reset / oe pin
  input  wire logic reset_oe_pol_i,             // 1: active-high reset
  input  wire logic config_serial_data_i,       // data pin level
  output logic      config_serial_data_o,       // data pin drive value
  output logic      config_serial_data_oe_o,    // data pin drive enable
  output logic      low_power_o,                // deselected, low power
  output logic      busy_o,                     // write or erase running
  output logic      fuse_set_o                  // security fuse state
);
  localparam int MB = cfgee_pkg::MEM_BYTES;
  localparam int AW = cfgee_pkg::MEM_AW;

  logic [5:0] pin_s;
  logic       req_s;
  logic       req_tgl;
  logic [8:0] req_addr;
  logic       dout;

  typedef cfgee_pkg::cfgee_tw_state_t cfgee_st_t;
  cfgee_st_t   st_ff;
  logic [3:0]  cnt_ff;
  logic [7:0]  sh_ff;
  logic [1:0]  abyte_ff;
  logic [23:0] addr_ff;
  logic        ackph_ff;
  logic        ack_ff;
  cfgee_st_t   after_ff;
  logic        od_oe_ff;
  logic        scl_prev_ff;
  logic        sda_prev_ff;
  logic        wrote_ff;
  logic        erase_req_ff;
  logic [2:0]  sec_cnt_ff;
  logic        sec_ones_ff;
  logic        sec_zero_ff;
  logic        wr_stb_ff;
  logic [AW-1:0] wr_idx_ff;
  logic [7:0]  wr_dat_ff;
  logic [cfgee_pkg::TMR_W-1:0] tmr_ff;
  logic        busy_ff;
  logic        erase_run_ff;
  logic        erase_stb_ff;
  logic        fuse_ff;
  logic        clr_pend_ff;
  logic        req_seen_ff;
  logic        ack_tgl_ff;
  logic [7:0]  rsp_ff;
  logic        oe_ff;
  logic        low_power_ff;
  logic [7:0]  mem_ff [MB];
  logic [MB-1:0] mem_we;

  cfgee_sync #(.W(6)) u_pin_sync (
    .clk_i  (clk_sys_i),
    .rstn_i (rstn_i),
    .d_i    ({reset_oe_pol_i, reset_oe_i, chip_select_i,
              serial_program_select_i, config_serial_clock_i,
              config_serial_data_i}),
    .q_o    (pin_s)
  );
  cfgee_sync #(.W(1)) u_req_sync (
    .clk_i  (clk_sys_i),
    .rstn_i (rstn_i),
    .d_i    (req_tgl),
    .q_o    (req_s)
  );

  cfgee_cfg_reader u_reader (
    .link_clk_i   (config_serial_clock_i),
    .rstn_i       (rstn_i),
    .prog_sel_n_i (serial_program_select_i),
    .chip_sel_i   (chip_select_i),
    .reset_oe_i   (reset_oe_i),
    .oe_pol_i     (reset_oe_pol_i),
    .ack_tgl_i    (ack_tgl_ff),
    .rsp_data_i   (rsp_ff),
    .req_tgl_o    (req_tgl),
    .req_addr_o   (req_addr),
    .dout_o       (dout)
  );

  // pin decode
  wire sda_s     = pin_s[0];
  wire scl_s     = pin_s[1];
  wire prog_mode = ~pin_s[2];
  wire cs_s      = pin_s[3];
  wire oe_act    = pin_s[5] ? pin_s[4] : ~pin_s[4];
  wire scl_rise  = scl_s & ~scl_prev_ff;
  wire scl_fall  = ~scl_s & scl_prev_ff;
  wire start_det = scl_s & scl_prev_ff & sda_prev_ff & ~sda_s;
  wire stop_det  = scl_s & scl_prev_ff & ~sda_prev_ff & sda_s;

  // two-wire byte assembly and read data select
  wire [7:0] new_byte = {sda_s, sh_ff[7:1]};
  wire       byte_done = scl_rise & (cnt_ff == cfgee_pkg::LAST_BIT);
  wire       sec_hit  = addr_ff[23:2] == cfgee_pkg::SEC_ADDR[23:2];
  wire       era_hit  = addr_ff == cfgee_pkg::ERASE_ADDR;
  wire       mem_hit  = addr_ff[23:AW] == '0;
  wire [7:0] fuse_byte = fuse_ff ? cfgee_pkg::FUSE_ON_BYTE
                                 : cfgee_pkg::FUSE_OFF_BYTE;
  wire [7:0] rd_byte = sec_hit ? fuse_byte :
                       mem_hit ? mem_ff[addr_ff[AW-1:0]] :
                                 cfgee_pkg::ERASED_BYTE;
  wire       dev_ack = (new_byte[6:0] == cfgee_pkg::DEV_ID) & ~busy_ff;
  wire [6:0] page_nxt = addr_ff[cfgee_pkg::PAGE_AW-1:0] + 7'h01;
  wire       sec_done = sec_cnt_ff == cfgee_pkg::SEC_BYTES;
  wire       cfg_drive = ~prog_mode & ~cs_s & ~oe_act & ~fuse_ff;

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      scl_prev_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
    end else begin
      scl_prev_ff <= scl_s;
      sda_prev_ff <= sda_s;
    end
  end

  // two-wire slave; chip select plays no part here
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_ff        <= cfgee_pkg::TW_IDLE;
      after_ff     <= cfgee_pkg::TW_IDLE;
      cnt_ff       <= 4'h0;
      sh_ff        <= 8'h00;
      abyte_ff     <= 2'h0;
      addr_ff      <= 24'h00_0000;
      ackph_ff     <= 1'b0;
      ack_ff       <= 1'b0;
      od_oe_ff     <= 1'b0;
      wrote_ff     <= 1'b0;
      erase_req_ff <= 1'b0;
      sec_cnt_ff   <= 3'h0;
      sec_ones_ff  <= 1'b0;
      sec_zero_ff  <= 1'b0;
      wr_stb_ff    <= 1'b0;
      wr_idx_ff    <= '0;
      wr_dat_ff    <= 8'h00;
    end else begin
      wr_stb_ff <= 1'b0;
      if (!prog_mode) begin
        st_ff    <= cfgee_pkg::TW_IDLE;
        od_oe_ff <= 1'b0;
      end else if (start_det) begin
        st_ff    <= cfgee_pkg::TW_DEV;
        cnt_ff   <= 4'h0;
        od_oe_ff <= 1'b0;
      end else if (stop_det) begin
        // the timer block consumes these flags on the same edge
        st_ff        <= cfgee_pkg::TW_IDLE;
        od_oe_ff     <= 1'b0;
        wrote_ff     <= 1'b0;
        erase_req_ff <= 1'b0;
        sec_cnt_ff   <= 3'h0;
      end else begin
        case (st_ff)
          cfgee_pkg::TW_DEV, cfgee_pkg::TW_ADR, cfgee_pkg::TW_WR: begin
            if (scl_rise) begin
              sh_ff  <= new_byte;
              cnt_ff <= cnt_ff + 4'h1;
            end
            if (byte_done) begin
              st_ff    <= cfgee_pkg::TW_ACK;
              ackph_ff <= 1'b0;
              ack_ff   <= 1'b1;
              after_ff <= cfgee_pkg::TW_WR;
              if (st_ff == cfgee_pkg::TW_DEV) begin
                ack_ff   <= dev_ack;
                abyte_ff <= 2'h0;
                after_ff <= new_byte[7] ? cfgee_pkg::TW_RD
                                        : cfgee_pkg::TW_ADR;
              end else if (st_ff == cfgee_pkg::TW_ADR) begin
                abyte_ff <= abyte_ff + 2'h1;
                case (abyte_ff)
                  2'h0:    addr_ff[23:16] <= new_byte;
                  2'h1:    addr_ff[15:8]  <= new_byte;
                  default: addr_ff[7:0]   <= new_byte;
                endcase
                if (abyte_ff != 2'h2) begin
                  after_ff <= cfgee_pkg::TW_ADR;
                end
                sec_cnt_ff  <= 3'h0;
                sec_ones_ff <= 1'b1;
                sec_zero_ff <= 1'b1;
              end else begin
                addr_ff[6:0] <= page_nxt;
                if (sec_hit) begin
                  if (!sec_done) begin
                    sec_cnt_ff <= sec_cnt_ff + 3'h1;
                  end
                  sec_ones_ff <= sec_ones_ff &
                                 (new_byte == cfgee_pkg::FUSE_ON_BYTE);
                  sec_zero_ff <= sec_zero_ff &
                                 (new_byte == cfgee_pkg::FUSE_OFF_BYTE);
                end else if (era_hit) begin
                  erase_req_ff <= 1'b1;
                end else if (mem_hit) begin
                  wr_stb_ff <= 1'b1;
                  wr_idx_ff <= addr_ff[AW-1:0];
                  wr_dat_ff <= new_byte;
                  wrote_ff  <= 1'b1;
                end
              end
            end
          end
          cfgee_pkg::TW_ACK: begin
            if (scl_fall && !ackph_ff) begin
              od_oe_ff <= ack_ff;
              ackph_ff <= 1'b1;
              if (!ack_ff) begin
                st_ff <= cfgee_pkg::TW_IDLE;
              end
            end else if (scl_fall) begin
              st_ff <= after_ff;
              if (after_ff == cfgee_pkg::TW_RD) begin
                od_oe_ff <= ~rd_byte[0];
                cnt_ff   <= 4'h1;
              end else begin
                od_oe_ff <= 1'b0;
                cnt_ff   <= 4'h0;
              end
            end
          end
          cfgee_pkg::TW_RD: begin
            if (scl_fall && cnt_ff == cfgee_pkg::BYTE_BITS) begin
              od_oe_ff <= 1'b0;
              st_ff    <= cfgee_pkg::TW_RACK;
            end else if (scl_fall) begin
              od_oe_ff <= ~rd_byte[cnt_ff[2:0]];
              cnt_ff   <= cnt_ff + 4'h1;
            end
          end
          cfgee_pkg::TW_RACK: begin
            if (scl_rise && !sda_s) begin
              addr_ff  <= addr_ff + 24'h00_0001;
              st_ff    <= cfgee_pkg::TW_ACK;
              ackph_ff <= 1'b1;
              after_ff <= cfgee_pkg::TW_RD;
            end else if (scl_rise) begin
              st_ff <= cfgee_pkg::TW_IDLE;
            end
          end
          default: st_ff <= cfgee_pkg::TW_IDLE;
        endcase
      end
    end
  end

  // self-timed cycles, fuse and erase sequencing
  wire stop_ev  = prog_mode & stop_det;
  wire set_fuse = stop_ev & sec_done & sec_ones_ff;
  wire zero_wr  = stop_ev & sec_done & sec_zero_ff;
  wire clr_try  = zero_wr & fuse_ff & ~clr_pend_ff;
  wire start_ec = (stop_ev & erase_req_ff) | clr_try;
  wire start_wr = stop_ev & (wrote_ff | (sec_done & ~clr_try));

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tmr_ff       <= '0;
      busy_ff      <= 1'b0;
      erase_run_ff <= 1'b0;
      erase_stb_ff <= 1'b0;
      fuse_ff      <= 1'b0;
      clr_pend_ff  <= 1'b0;
    end else begin
      erase_stb_ff <= 1'b0;
      if (start_ec) begin
        tmr_ff       <= T_EC_CYC;
        busy_ff      <= 1'b1;
        erase_run_ff <= 1'b1;
      end else if (start_wr) begin
        tmr_ff  <= T_WR_CYC;
        busy_ff <= 1'b1;
      end else if (busy_ff && tmr_ff == 22'h00_0001) begin
        busy_ff      <= 1'b0;
        erase_run_ff <= 1'b0;
        erase_stb_ff <= erase_run_ff;
        tmr_ff       <= '0;
      end else if (busy_ff) begin
        tmr_ff <= tmr_ff - 22'h00_0001;
      end
      if (set_fuse) begin
        fuse_ff <= 1'b1;
      end else if (clr_try) begin
        clr_pend_ff <= 1'b1;
      end else if (zero_wr && clr_pend_ff) begin
        fuse_ff     <= 1'b0;
        clr_pend_ff <= 1'b0;
      end
    end
  end

  // memory: one flop byte per entry, erased all at once
  for (genvar i = 0; i < MB; i++) begin : g_mem
    assign mem_we[i] = wr_stb_ff & (wr_idx_ff == AW'(i));
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
        mem_ff[i] <= cfgee_pkg::ERASED_BYTE;
      end else if (erase_stb_ff) begin
        mem_ff[i] <= cfgee_pkg::ERASED_BYTE;
      end else if (mem_we[i]) begin
        mem_ff[i] <= wr_dat_ff;
      end
    end
  end

  // fetch answers for the streamer; the address is stable while pending
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      req_seen_ff <= 1'b0;
      ack_tgl_ff  <= 1'b0;
      rsp_ff      <= 8'h00;
    end else if (req_s != req_seen_ff) begin
      req_seen_ff <= req_s;
      ack_tgl_ff  <= ~ack_tgl_ff;
      rsp_ff      <= fuse_ff ? 8'h00 : mem_ff[req_addr];
    end
  end

  // pad enable: tri-state streamer or open-drain slave
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      oe_ff        <= 1'b0;
      low_power_ff <= 1'b0;
    end else begin
      oe_ff        <= prog_mode ? od_oe_ff : cfg_drive;
      low_power_ff <= ~prog_mode & cs_s;
    end
  end

  assign config_serial_data_o    = dout;
  assign config_serial_data_oe_o = oe_ff;
  assign low_power_o             = low_power_ff;
  assign busy_o                  = busy_ff;
  assign fuse_set_o              = fuse_ff;
endmodule : cfgee_top

// ==== rtl/cfgee_pkg.sv ====
/*
 * Shared constants and types of the configuration memory block: timing,
 * memory geometry, special addresses and the two-wire state encoding.
 * Assumes a 100 MHz system clock.
 */
package cfgee_pkg;
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          T_WR_MS       = 20;  // self-timed page write
  localparam int          T_EC_MS       = 25;  // chip erase cycle
  localparam int          NS_PER_MS     = 1_000_000;
  localparam int          TMR_W         = 22;
  localparam logic [21:0] T_WR_CYC = 22'(T_WR_MS * NS_PER_MS / CLK_PERIOD_NS);
  localparam logic [21:0] T_EC_CYC = 22'(T_EC_MS * NS_PER_MS / CLK_PERIOD_NS);
  localparam int          MEM_BYTES     = 512;
  localparam int          MEM_AW        = 9;
  localparam int          PAGE_AW       = 7;   // 128-byte page
  localparam logic [23:0] SEC_ADDR      = 24'h80_0000;
  localparam logic [23:0] ERASE_ADDR    = 24'hC0_0000;
  localparam logic [6:0]  DEV_ID        = 7'h50;  // arbitrary value
  localparam logic [7:0]  ERASED_BYTE   = 8'hFF;
  localparam logic [7:0]  FUSE_ON_BYTE  = 8'hFF;
  localparam logic [7:0]  FUSE_OFF_BYTE = 8'h00;
  localparam logic [2:0]  SEC_BYTES     = 3'h4;
  localparam logic [3:0]  LAST_BIT      = 4'h7;
  localparam logic [3:0]  BYTE_BITS     = 4'h8;

  typedef enum logic [2:0] {
    TW_IDLE, TW_DEV, TW_ADR, TW_WR, TW_ACK, TW_RD, TW_RACK
  } cfgee_tw_state_t;
endpackage : cfgee_pkg

// ==== rtl/cfgee_sync.sv ====
/*
 * Two-flop level synchroniser of configurable width.
 * Assumes inputs are quasi-static levels relative to clk_i.
 */
`timescale 1ns/10ps
module cfgee_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,   // destination clock
  input  wire logic         rstn_i,  // async reset, active low
  input  wire logic [W-1:0] d_i,     // asynchronous levels
  output logic      [W-1:0] q_o      // synchronised levels
);
  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s1_ff <= '0;
      s2_ff <= '0;
    end else begin
      s1_ff <= d_i;
      s2_ff <= s1_ff;
    end
  end

  assign q_o = s2_ff;
endmodule : cfgee_sync

// ==== rtl/cfgee_cfg_reader.sv ====
/*
 * Configuration-mode streamer on the serial link clock: bit and address
 * counters, output shift register and a toggle handshake that fetches
 * bytes from the memory in the system clock domain.
 * Assumes the link clock runs while data is streamed.
 */
`timescale 1ns/10ps
module cfgee_cfg_reader (
  input  wire logic       link_clk_i,   // serial link clock
  input  wire logic       rstn_i,       // async reset, active low
  input  wire logic       prog_sel_n_i, // low selects programming
  input  wire logic       chip_sel_i,   // chip select, high deselects
  input  wire logic       reset_oe_i,   // counter reset / output enable
  input  wire logic       oe_pol_i,     // 1: active-high counter reset
  input  wire logic       ack_tgl_i,    // fetch answer toggle
  input  wire logic [7:0] rsp_data_i,   // fetched byte
  output logic            req_tgl_o,    // fetch request toggle
  output logic [8:0]      req_addr_o,   // fetch address
  output logic            dout_o        // serial data bit
);
  logic [3:0] pin_s;
  logic       ack_s;
  logic [2:0] bit_ff;
  logic [8:0] fetch_ff;
  logic [7:0] byte_ff;
  logic [7:0] pre_ff;
  logic       need_ff;
  logic       in_rst_ff;
  logic       ack_seen_ff;
  logic       req_ff;
  logic [8:0] req_addr_ff;

  localparam logic [2:0] LAST_BIT_3 = cfgee_pkg::LAST_BIT[2:0];

  cfgee_sync #(.W(4)) u_pin_sync (
    .clk_i  (link_clk_i),
    .rstn_i (rstn_i),
    .d_i    ({oe_pol_i, reset_oe_i, chip_sel_i, prog_sel_n_i}),
    .q_o    (pin_s)
  );
  cfgee_sync #(.W(1)) u_ack_sync (
    .clk_i  (link_clk_i),
    .rstn_i (rstn_i),
    .d_i    (ack_tgl_i),
    .q_o    (ack_s)
  );

  wire cfg_mode = pin_s[0];
  wire oe_act   = pin_s[3] ? pin_s[2] : ~pin_s[2];
  wire ctr_rst  = cfg_mode & oe_act;
  wire run      = cfg_mode & ~pin_s[1] & ~oe_act;
  wire pending  = req_ff ^ ack_seen_ff;
  wire got      = ack_s ^ ack_seen_ff;

  always_ff @(posedge link_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bit_ff      <= 3'h0;
      fetch_ff    <= 9'h000;
      byte_ff     <= 8'h00;
      pre_ff      <= 8'h00;
      need_ff     <= 1'b1;
      in_rst_ff   <= 1'b1;
      ack_seen_ff <= 1'b0;
      req_ff      <= 1'b0;
      req_addr_ff <= 9'h000;
    end else begin
      ack_seen_ff <= ack_s;
      if (got) begin
        pre_ff <= rsp_data_i;
      end
      in_rst_ff <= ctr_rst;
      if (!cfg_mode) begin
        byte_ff <= 8'h00;  // open-drain value in programming mode
        bit_ff  <= 3'h0;
      end else if (ctr_rst) begin
        bit_ff   <= 3'h0;
        fetch_ff <= 9'h000;
        byte_ff  <= got ? rsp_data_i : pre_ff;
        need_ff  <= need_ff | ~in_rst_ff;
      end else if (in_rst_ff) begin
        fetch_ff <= 9'h001;
        need_ff  <= 1'b1;
      end else if (run) begin
        bit_ff <= bit_ff + 3'h1;
        if (bit_ff == LAST_BIT_3) begin
          byte_ff  <= pre_ff;
          fetch_ff <= fetch_ff + 9'h001;
          need_ff  <= 1'b1;
        end else begin
          byte_ff <= {1'b0, byte_ff[7:1]};
        end
      end
      if (need_ff && !pending) begin
        req_ff      <= ~req_ff;
        req_addr_ff <= fetch_ff;
        need_ff     <= 1'b0;
      end
    end
  end

  assign req_tgl_o  = req_ff;
  assign req_addr_o = req_addr_ff;
  assign dout_o     = byte_ff[0];
endmodule : cfgee_cfg_reader

// ==== tb/cfgee_checker.sv ====
/* pin-level assertions for the configuration memory.
   bound to cfgee_top from the bench top file. */
`timescale 1ns/10ps
module cfgee_checker (
  input wire logic clk_sys_i,               // sys clock
  input wire logic rstn_i,                  // reset
  input wire logic config_serial_clock_i,   // link clock
  input wire logic serial_program_select_i, // mode
  input wire logic chip_select_i,           // select
  input wire logic reset_oe_i,              // counter reset
  input wire logic reset_oe_pol_i,          // its polarity
  input wire logic config_serial_data_o,    // drive value
  input wire logic config_serial_data_oe_o, // drive enable
  input wire logic low_power_o,             // low power
  input wire logic busy_o,                  // write cycle
  input wire logic fuse_set_o               // fuse
);
  wire sel  = serial_program_select_i;
  wire oe   = config_serial_data_oe_o;
  wire dout = config_serial_data_o;
  default clocking dc @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  sequence s_desel;
    sel && chip_select_i;
  endsequence
  sequence s_rst;
    sel && reset_oe_i == reset_oe_pol_i;
  endsequence
  // five cycles leave room for the pin synchronisers
  chk_oe_desel: assert property (s_desel [*5] |-> !oe)
    else $error("drive on while deselected");
  chk_oe_reset: assert property (s_rst [*5] |-> !oe)
    else $error("drive on during counter reset");
  chk_lp_on: assert property (s_desel [*5] |-> low_power_o)
    else $error("low power missing");
  chk_lp_prog: assert property ((!sel) [*5] |-> !low_power_o)
    else $error("low power in programming");
  chk_fuse_quiet: assert property ((sel && fuse_set_o) [*5] |-> !oe)
    else $error("data driven with fuse set");
  chk_open_drain: assert property ((!sel) [*5] ##0 oe |-> !dout)
    else $error("line driven high");
  chk_busy_nack: assert property ((!sel && busy_o) [*2] |-> !oe)
    else $error("drive during write cycle");
  chk_fuse_mode: assert property ($changed(fuse_set_o) |-> !sel)
    else $error("fuse changed in config mode");
  // byte 0 lands a few link clocks into the reset, so wait sixteen
  chk_rst_hold: assert property (@(posedge config_serial_clock_i)
    disable iff (!rstn_i) s_rst [*8] ##1 s_rst [*8] |-> $stable(dout))
    else $error("data moved in counter reset");
  chk_desel_hold: assert property (@(posedge config_serial_clock_i)
    disable iff (!rstn_i) s_desel [*8] |-> $stable(dout))
    else $error("data moved while deselected");
endmodule : cfgee_checker

// ==== tb/cfgee_prog_model.sv ====
/* two-wire programmer: start, stop, bytes LSB first.
   assumes the bench resolves the pulled-up data wire. */
`timescale 1ns/10ps
module cfgee_prog_model (
  input  wire logic clk_i,    // bench clock
  input  wire logic sda_i,    // wire level
  output logic      scl_o,    // clock, high when idle
  output logic      sda_oe_o  // pulls wire low
);
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end
  task automatic hp;
    repeat (8) @(posedge clk_i);
    #1;
  endtask : hp
  task automatic bit_io(input logic b, output logic s);
    sda_oe_o = !b;
    hp;
    scl_o = 1'b1;
    hp;
    s = sda_i;
    scl_o = 1'b0;
  endtask : bit_io
  task automatic start;
    sda_oe_o = 1'b0;
    hp;
    scl_o = 1'b1;
    hp;
    sda_oe_o = 1'b1;
    hp;
    scl_o = 1'b0;
  endtask : start
  task automatic stop;
    sda_oe_o = 1'b1;
    hp;
    scl_o = 1'b1;
    hp;
    sda_oe_o = 1'b0;
    hp;
  endtask : stop
  task automatic xfer(input logic [7:0] b, input logic m,
                      output logic [7:0] r, output logic s);
    for (int i = 0; i < 8; i++) bit_io(b[i], r[i]);
    bit_io(m, s);
  endtask : xfer
endmodule : cfgee_prog_model

// ==== tb/test_config_eeprom_program_control.sv ====
/* bench: control rows, page write, streaming, fuse, chip erase.
   assumes shortened write and erase cycles set below. */
`timescale 1ns/10ps
`define CHK(n, e, s) check(n, 32'(e), 32'(s))
module test_config_eeprom_program_control;
  logic clk = 0, rstn = 0, lclk = 0, run = 0;
  logic sps = 1, cs = 0, roe = 1, pol = 1, ak;
  logic dout, doe, lp, busy, fuse, scl, sda_oe, sda, sck;
  logic [7:0] rb;
  int n_fail = 0, comparisons = 0;
  // {sel, cs, counter reset, polarity, oe, low power}
  logic [5:0] rows [7] = '{6'h26, 6'h2c, 6'h35, 6'h2a, 6'h20, 6'h14, 6'h08};
  assign sck = sps ? lclk : scl;
  // undriven config line shows the inverse, never a stale value
  assign sda = sps ? (doe ? dout : !dout) : !((doe && !dout) || sda_oe);
  cfgee_top #(.T_WR_CYC(22'h0c8), .T_EC_CYC(22'h12c)) u_dut (
    .clk_sys_i(clk), .rstn_i(rstn), .config_serial_clock_i(sck),
    .serial_program_select_i(sps), .chip_select_i(cs), .reset_oe_i(roe),
    .reset_oe_pol_i(pol), .config_serial_data_i(sda),
    .config_serial_data_o(dout), .config_serial_data_oe_o(doe),
    .low_power_o(lp), .busy_o(busy), .fuse_set_o(fuse));
  cfgee_prog_model u_prog (.clk_i(clk), .sda_i(sda), .scl_o(scl),
    .sda_oe_o(sda_oe));
  initial forever #5 clk = !clk;
  initial begin
    #3;
    forever #16 lclk = run && !lclk;
  end
  task automatic check(string n, logic [31:0] e, logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : check
  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic poll(input logic rw);
    u_prog.start;
    u_prog.xfer({rw, cfgee_pkg::DEV_ID}, 1'b1, rb, ak);
  endtask : poll
  task automatic addr(input logic [23:0] a);
    poll(1'b0);
    for (int i = 3; i >= 0; i--) begin
      `CHK("ack", 0, ak);
      if (i > 0) u_prog.xfer(a[i*8-8 +: 8], 1'b1, rb, ak);
    end
  endtask : addr
  task automatic wr(input logic [23:0] a, input int n,
                    input logic [7:0] d, input logic [7:0] m);
    addr(a);
    for (int k = 0; k < n; k++) begin
      u_prog.xfer(d ^ (8'(k) & m), 1'b1, rb, ak);
      `CHK("data ack", 0, ak);
    end
    u_prog.stop;
    `CHK("busy", 1, busy);
  endtask : wr
  task automatic rd(input logic [23:0] a, input int n, input logic [7:0] e);
    addr(a);
    poll(1'b1);
    for (int k = 0; k < n; k++) begin
      u_prog.xfer(8'hff, k == n - 1, rb, ak);
      `CHK("rd byte", e, rb);
    end
    u_prog.stop;
  endtask : rd
  task automatic idle;
    for (int i = 0; i < 400 && busy === 1'b1; i++) tick(1);
    `CHK("busy end", 0, busy);
  endtask : idle
  task automatic stream;
    logic [7:0] e;
    int p;
    run = 1;
    tick(400);
    `CHK("bit0", 0, dout);
    roe = 0;
    // byte 0 bit 0 stands until the counters are released
    for (p = 0; p < 8 && dout !== 1'b1; p++) @(negedge lclk);
    for (p = 1; p < 1040; p++) begin
      e = p < 1024 ? ((8'(p >> 3) + 8'h02) & 8'h7f) ^ 8'h3c : 8'hff;
      `CHK("stream", e[p[2:0]], dout);
      @(negedge lclk);
    end
    tick(1);
    cs = 1;
    tick(60);
    `CHK("low power", 1, lp);
    run = 0;
  endtask : stream
  initial begin
    tick(10);
    rstn = 1;
    tick(4);
    `CHK("fuse rst", 0, fuse);
    foreach (rows[i]) begin
      {sps, cs, roe, pol} = rows[i][5:2];
      tick(8);
      `CHK("row oe", rows[i][1], doe);
      `CHK("row lp", rows[i][0], lp);
    end
    $display("rows done");
    wr(24'h00_007e, 128, 8'h3c, 8'hff);
    poll(1'b0);
    `CHK("write nack", 1, ak);
    idle;
    {sps, cs, roe, pol} = 4'hb;
    stream;
    $display("stream done");
    sps = 0;
    tick(8);
    wr(cfgee_pkg::SEC_ADDR, 4, 8'hff, 8'h00);
    idle;
    `CHK("fuse on", 1, fuse);
    rd(cfgee_pkg::SEC_ADDR, 4, 8'hff);
    rd(cfgee_pkg::SEC_ADDR, 4, 8'hff);
    {sps, cs, roe, pol} = 4'h9;
    tick(8);
    `CHK("fuse oe", 0, doe);
    sps = 0;
    tick(8);
    wr(cfgee_pkg::SEC_ADDR, 4, 8'h00, 8'h00);
    idle;
    `CHK("fuse kept", 1, fuse);
    wr(cfgee_pkg::SEC_ADDR, 4, 8'h00, 8'h00);
    idle;
    `CHK("fuse off", 0, fuse);
    rd(cfgee_pkg::SEC_ADDR, 4, 8'h00);
    rd(24'h00_0000, 2, 8'hff);
    $display("fuse done");
    wr(cfgee_pkg::ERASE_ADDR, 1, 8'h00, 8'h00);
    poll(1'b0);
    `CHK("erase nack", 1, ak);
    tick(80);
    `CHK("erase busy", 1, busy);
    idle;
    $display("erase done");
    results;
  end
  initial begin
    tick(60000);
    n_fail++;
    results;
  end
endmodule : test_config_eeprom_program_control
bind cfgee_top cfgee_checker u_chk (.clk_sys_i, .rstn_i,
  .config_serial_clock_i, .serial_program_select_i, .chip_select_i,
  .reset_oe_i, .reset_oe_pol_i, .config_serial_data_o,
  .config_serial_data_oe_o, .low_power_o, .busy_o, .fuse_set_o);
